// ===== brd_pkg.sv
// Shared constants and types for the byte rotate datapath
package brd_pkg;
   localparam int DATA_W = 8;
   localparam int BANK_W = 4;
   localparam int ADDR_W = 12;
   // Split point of the access bank: low part maps to bank 0, rest to the top bank
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   // Highest file address that takes the indexed literal offset path
   localparam logic [7:0] INDEXED_MAX = 8'h5f;
   localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
   localparam logic [7:0] W_RESET = 8'h00;
   localparam logic C_RESET = 1'b0;
   localparam logic N_RESET = 1'b0;
   localparam logic Z_RESET = 1'b0;
   // Cycles from a taken request to the DONE pulse
   localparam int DONE_LATENCY = 3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_READ = 3'b010,
      ST_EXEC = 3'b100
   } brd_state_type;

   typedef enum logic {
      OP_RL_NO_CARRY = 1'b0,
      OP_RR_VIA_CARRY = 1'b1
   } brd_op_type;
endpackage

// ===== brd_mem_if.sv
// Carrier between the datapath control and the file register memory
`timescale 1ns/1ps
interface brd_mem_if #(parameter int AW = 12, parameter int DW = 8);
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;
   logic we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   modport ctrl (output raddr, input rdata, output we, output waddr, output wdata);
   modport mem (input raddr, output rdata, input we, input waddr, input wdata);
endinterface

// ===== brd_file_mem.sv
// File register memory with registered read data
`timescale 1ns/1ps
module brd_file_mem #(
   parameter int AW = 12,
   parameter int DW = 8
) (
   input wire logic clk,
   brd_mem_if.mem port
);
   logic [DW-1:0] mem_q [2**AW];
   logic [DW-1:0] rdata_q;

   // Memory contents are left unreset; only the read register matters to control
   always_ff @(posedge clk) begin
      if (port.we) begin
         mem_q[port.waddr] <= port.wdata;
      end
      rdata_q <= mem_q[port.raddr];
   end

   assign port.rdata = rdata_q;
endmodule // brd_file_mem

// ===== brd_rotate_top.sv
// Rotate datapath: left rotate without carry, right rotate through carry
// Functional notes
// RQ1: Left rotate without carry moves each bit up one place, old bit 7 to bit 0, carry kept.
// RQ2: Right rotate via carry moves each bit down, old bit 0 to carry, old carry to bit 7.
// RQ3: Destination bit zero writes the result to W, one writes it back to the file register.
// RQ4: Access bit zero resolves through the access bank, one through the bank select value.
// RQ5: Access bit zero, extended set on and address at most 95 uses indexed literal offset.
// RQ6: Each rotate takes an 8-bit file address plus one destination and one access bit.
// RQ7: Zero flag is set for an all-zero result and negative flag copies result bit 7.
`timescale 1ns/1ps
module brd_rotate_top #(
   parameter int AW = brd_pkg::ADDR_W
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic NRST,
   // Instruction request
   input wire logic OP_VALID,
   input wire logic OP_SEL,
   input wire logic [7:0] OP_FILE,
   input wire logic OP_DEST,
   input wire logic OP_ACCESS,
   // Core context
   input wire logic EXT_SET_EN,
   input wire logic [3:0] BANK_SEL,
   input wire logic [AW-1:0] INDEX_BASE,
   input wire logic CARRY_LOAD,
   input wire logic CARRY_IN,
   // File register preload
   input wire logic LOAD_VALID,
   input wire logic [AW-1:0] LOAD_ADDR,
   input wire logic [7:0] LOAD_DATA,
   // Status and results
   output logic BUSY,
   output logic DONE,
   output logic [7:0] RESULT,
   output logic [AW-1:0] RESULT_ADDR,
   output logic RESULT_TO_FILE,
   output logic [7:0] W_REG,
   output logic CARRY,
   output logic NEG,
   output logic ZERO
);
   typedef struct packed {
      brd_pkg::brd_state_type st;
      brd_pkg::brd_op_type op;
      logic dest;
      logic [AW-1:0] addr;
      logic [7:0] w;
      logic c;
      logic n;
      logic z;
      logic busy;
      logic done;
      logic to_file;
      logic [7:0] result;
   } brd_regs_type;

   brd_regs_type r_q;
   brd_regs_type r_d;
   logic [7:0] rot_res;
   logic rot_c;
   logic [7:0] rdata;

   brd_mem_if #(.AW(AW), .DW(8)) mem_bus ();

   brd_file_mem #(.AW(AW), .DW(8)) u_mem (
      .clk(CLK_SYS),
      .port(mem_bus)
   );

   assign rdata = mem_bus.rdata;

   always_comb begin
      r_d = r_q;
      r_d.done = 1'b0;
      rot_res = rdata;
      rot_c = r_q.c;
      if (r_q.op == brd_pkg::OP_RL_NO_CARRY) begin
         rot_res = {rdata[6:0], rdata[7]}; // see RQ1
      end else begin
         rot_res = {r_q.c, rdata[7:1]}; // see RQ2
         rot_c = rdata[0]; // see RQ2
      end
      mem_bus.raddr = r_q.addr;
      mem_bus.we = 1'b0;
      mem_bus.waddr = LOAD_ADDR;
      mem_bus.wdata = LOAD_DATA;
      // Preload only when idle so it never races a write-back
      if (LOAD_VALID && r_q.st == brd_pkg::ST_IDLE) begin
         mem_bus.we = 1'b1;
      end
      if (CARRY_LOAD && r_q.st == brd_pkg::ST_IDLE) begin
         r_d.c = CARRY_IN;
      end
      case (r_q.st)
         brd_pkg::ST_IDLE: begin
            if (OP_VALID) begin
               // Full 8-bit address plus two select bits taken here, see RQ6
               r_d.op = brd_pkg::brd_op_type'(OP_SEL);
               r_d.dest = OP_DEST;
               r_d.busy = 1'b1;
               r_d.st = brd_pkg::ST_READ;
               if (OP_ACCESS) begin
                  r_d.addr = AW'({BANK_SEL, OP_FILE}); // see RQ4
               end else if (EXT_SET_EN && OP_FILE <= brd_pkg::INDEXED_MAX) begin
                  r_d.addr = AW'(INDEX_BASE + AW'(OP_FILE)); // see RQ5
               end else if (OP_FILE < brd_pkg::ACCESS_SPLIT) begin
                  r_d.addr = AW'({brd_pkg::ACCESS_LO_BANK, OP_FILE}); // see RQ4
               end else begin
                  r_d.addr = AW'({brd_pkg::ACCESS_HI_BANK, OP_FILE}); // see RQ4
               end
            end
         end
         brd_pkg::ST_READ: begin
            r_d.st = brd_pkg::ST_EXEC;
         end
         brd_pkg::ST_EXEC: begin
            r_d.st = brd_pkg::ST_IDLE;
            r_d.busy = 1'b0;
            r_d.done = 1'b1;
            r_d.result = rot_res;
            r_d.to_file = r_q.dest;
            r_d.c = rot_c;
            r_d.z = (rot_res == 8'h00); // see RQ7
            r_d.n = rot_res[7]; // see RQ7
            if (r_q.dest) begin
               mem_bus.we = 1'b1; // see RQ3
               mem_bus.waddr = r_q.addr;
               mem_bus.wdata = rot_res;
            end else begin
               r_d.w = rot_res; // see RQ3
            end
         end
         default: begin
            r_d.st = brd_pkg::ST_IDLE;
            r_d.busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         r_q <= '{st: brd_pkg::ST_IDLE, op: brd_pkg::OP_RL_NO_CARRY, dest: 1'b0,
                  addr: '0, w: brd_pkg::W_RESET, c: brd_pkg::C_RESET,
                  n: brd_pkg::N_RESET, z: brd_pkg::Z_RESET, busy: 1'b0,
                  done: 1'b0, to_file: 1'b0, result: 8'h00};
      end else begin
         r_q <= r_d;
      end
   end

   assign BUSY = r_q.busy;
   assign DONE = r_q.done;
   assign RESULT = r_q.result;
   assign RESULT_ADDR = r_q.addr;
   assign RESULT_TO_FILE = r_q.to_file;
   assign W_REG = r_q.w;
   assign CARRY = r_q.c;
   assign NEG = r_q.n;
   assign ZERO = r_q.z;

   // Checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);

   logic exec_rl;
   logic exec_rr;
   logic [7:0] exp_rl;
   logic [7:0] exp_rr;
   assign exec_rl = (r_q.st == brd_pkg::ST_EXEC) && (r_q.op == brd_pkg::OP_RL_NO_CARRY);
   assign exec_rr = (r_q.st == brd_pkg::ST_EXEC) && (r_q.op == brd_pkg::OP_RR_VIA_CARRY);
   assign exp_rl = {rdata[6:0], rdata[7]};
   assign exp_rr = {r_q.c, rdata[7:1]};

   sequence take_s;
      OP_VALID && r_q.st == brd_pkg::ST_IDLE;
   endsequence
   sequence run_s;
      BUSY [*2] ##1 (DONE && !BUSY);
   endsequence
   // Taken request that uses neither the bank select nor the indexed window
   sequence acc_bank_s;
      take_s ##0 (!OP_ACCESS && !(EXT_SET_EN && OP_FILE <= brd_pkg::INDEXED_MAX));
   endsequence

   op_latency_a: assert property (take_s |=> run_s) // see RQ6
      else $error("rotate did not complete three cycles after request");
   done_pulse_a: assert property (DONE |=> !DONE) // see RQ6
      else $error("done held longer than one cycle");
   refused_op_a: assert property (BUSY && OP_VALID |=> $stable(RESULT_ADDR)) // see RQ6
      else $error("request taken while busy");
   rl_value_a: assert property ( // see RQ1
      exec_rl |=> RESULT == $past(exp_rl) && CARRY == $past(r_q.c))
      else $error("left rotate result or carry wrong");
   rr_value_a: assert property ( // see RQ2
      exec_rr |=> RESULT == $past(exp_rr) && CARRY == $past(rdata[0]))
      else $error("right rotate through carry wrong");
   dest_w_a: assert property (DONE && !RESULT_TO_FILE |-> W_REG == RESULT) // see RQ3
      else $error("result not placed in W");
   w_keep_a: assert property (DONE && RESULT_TO_FILE |-> $stable(W_REG)) // see RQ3
      else $error("W changed although result went to file");
   dest_file_a: assert property ( // see RQ3
      (r_q.st == brd_pkg::ST_EXEC) && r_q.dest
      |-> mem_bus.we && mem_bus.waddr == r_q.addr)
      else $error("result not written back to file register");
   file_data_a: assert property ( // see RQ3
      (r_q.st == brd_pkg::ST_EXEC) && r_q.dest
      |-> mem_bus.wdata == (exec_rl ? exp_rl : exp_rr))
      else $error("file write-back data wrong");
   bank_sel_a: assert property ( // see RQ4
      take_s ##0 OP_ACCESS |=> RESULT_ADDR == AW'($past({BANK_SEL, OP_FILE})))
      else $error("banked address wrong");
   access_lo_a: assert property ( // see RQ4
      acc_bank_s ##0 (OP_FILE < brd_pkg::ACCESS_SPLIT)
      |=> RESULT_ADDR == AW'({brd_pkg::ACCESS_LO_BANK, $past(OP_FILE)}))
      else $error("access bank low half address wrong");
   access_hi_a: assert property ( // see RQ4
      acc_bank_s ##0 (OP_FILE >= brd_pkg::ACCESS_SPLIT)
      |=> RESULT_ADDR == AW'({brd_pkg::ACCESS_HI_BANK, $past(OP_FILE)}))
      else $error("access bank high half address wrong");
   indexed_mode_a: assert property ( // see RQ5
      take_s ##0 (!OP_ACCESS && EXT_SET_EN && OP_FILE <= brd_pkg::INDEXED_MAX)
      |=> RESULT_ADDR == AW'($past(INDEX_BASE) + AW'($past(OP_FILE))))
      else $error("indexed literal offset address wrong");
   flags_a: assert property ( // see RQ7
      DONE |-> ZERO == (RESULT == 8'h00) && NEG == RESULT[7])
      else $error("zero or negative flag wrong");
endmodule // brd_rotate_top

// ===== brd_rotate_top_bench.sv
// Self-checking bench for the byte rotate datapath
`timescale 1ns/1ps
module brd_rotate_top_bench;
   logic CLK_SYS = 1'b0;
   logic NRST = 1'b0;
   logic OP_VALID = 1'b0, OP_SEL = 1'b0, OP_DEST = 1'b0, OP_ACCESS = 1'b0;
   logic [7:0] OP_FILE = 8'h00, LOAD_DATA = 8'h00;
   logic EXT_SET_EN = 1'b0, CARRY_LOAD = 1'b0, CARRY_IN = 1'b0, LOAD_VALID = 1'b0;
   logic [3:0] BANK_SEL = 4'h0;
   logic [11:0] INDEX_BASE = 12'h000, LOAD_ADDR = 12'h000;
   logic BUSY, DONE, RESULT_TO_FILE, CARRY, NEG, ZERO;
   logic [7:0] RESULT, W_REG;
   logic [11:0] RESULT_ADDR;
   int n_errors = 0;
   int cmp_count = 0;
   int cycles = 0;

   brd_rotate_top i_dut (
      .CLK_SYS(CLK_SYS), .NRST(NRST), .OP_VALID(OP_VALID), .OP_SEL(OP_SEL),
      .OP_FILE(OP_FILE), .OP_DEST(OP_DEST), .OP_ACCESS(OP_ACCESS),
      .EXT_SET_EN(EXT_SET_EN), .BANK_SEL(BANK_SEL), .INDEX_BASE(INDEX_BASE),
      .CARRY_LOAD(CARRY_LOAD), .CARRY_IN(CARRY_IN), .LOAD_VALID(LOAD_VALID),
      .LOAD_ADDR(LOAD_ADDR), .LOAD_DATA(LOAD_DATA), .BUSY(BUSY), .DONE(DONE),
      .RESULT(RESULT), .RESULT_ADDR(RESULT_ADDR), .RESULT_TO_FILE(RESULT_TO_FILE),
      .W_REG(W_REG), .CARRY(CARRY), .NEG(NEG), .ZERO(ZERO)
   );

   always #2 CLK_SYS = ~CLK_SYS;

   // Whole run needs under a hundred cycles; ceiling leaves wide margin
   always @(posedge CLK_SYS) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors++;
         summarize();
      end
   end

   task automatic summarize();
      $display("mismatches %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic load(input logic [11:0] a, input logic [7:0] d);
      @(posedge CLK_SYS);
      LOAD_VALID <= 1'b1;
      LOAD_ADDR <= a;
      LOAD_DATA <= d;
      @(posedge CLK_SYS);
      LOAD_VALID <= 1'b0;
   endtask

   task automatic set_carry(input logic v);
      @(posedge CLK_SYS);
      CARRY_LOAD <= 1'b1;
      CARRY_IN <= v;
      @(posedge CLK_SYS);
      CARRY_LOAD <= 1'b0;
   endtask

   // One request, waited for under a bound, then all outputs but CARRY judged, W_REG only for a W destination
   task automatic op(input logic sel, input logic [7:0] f, input logic dest, input logic acc,
                     input logic [7:0] exp, input logic [11:0] ea);
      int n;
      // Count starts at one: the edge that takes the request ends cycle zero
      n = 1;
      @(posedge CLK_SYS);
      OP_VALID <= 1'b1;
      OP_SEL <= sel;
      OP_FILE <= f;
      OP_DEST <= dest;
      OP_ACCESS <= acc;
      @(posedge CLK_SYS);
      OP_VALID <= 1'b0;
      do begin
         @(posedge CLK_SYS);
         #1;
         n++;
         if (DONE !== 1'b1) chk("busy", 12'h001, {11'h000, BUSY});
      end while (DONE !== 1'b1 && n < 8);
      chk("busy_end", 12'h000, {11'h000, BUSY});
      chk("latency", 12'(brd_pkg::DONE_LATENCY), 12'(n));
      chk("result", {4'h0, exp}, {4'h0, RESULT});
      chk("address", ea, RESULT_ADDR);
      chk("to_file", {11'h000, dest}, {11'h000, RESULT_TO_FILE});
      chk("neg", {11'h000, exp[7]}, {11'h000, NEG});
      chk("zero", {11'h000, exp == 8'h00}, {11'h000, ZERO});
      if (!dest) chk("w_reg", {4'h0, exp}, {4'h0, W_REG});
   endtask

   // Outputs right after reset release show their reset values
   task automatic t_reset();
      @(posedge CLK_SYS);
      #1;
      chk("rst_flags", 12'h000, {6'h00, BUSY, DONE, RESULT_TO_FILE, CARRY, NEG, ZERO});
      chk("rst_w", 12'h000, {4'h0, W_REG});
      chk("rst_result", 12'h000, {4'h0, RESULT});
      chk("rst_addr", 12'h000, RESULT_ADDR);
   endtask

   task automatic t_left();
      @(posedge CLK_SYS);
      BANK_SEL <= 4'h3;
      load(12'h320, 8'hab);
      set_carry(1'b1);
      op(1'b0, 8'h20, 1'b0, 1'b1, 8'h57, 12'h320);
      chk("carry", 12'h001, {11'h000, CARRY});
      op(1'b0, 8'h20, 1'b1, 1'b1, 8'h57, 12'h320);
      op(1'b0, 8'h20, 1'b0, 1'b1, 8'hae, 12'h320);
   endtask

   task automatic t_right();
      load(12'hfff, 8'h01);
      set_carry(1'b0);
      op(1'b1, 8'hff, 1'b1, 1'b0, 8'h00, 12'hfff);
      chk("carry", 12'h001, {11'h000, CARRY});
      op(1'b1, 8'hff, 1'b0, 1'b0, 8'h80, 12'hfff);
      chk("carry", 12'h000, {11'h000, CARRY});
   endtask

   // Boundary of the indexed window: 0x5f indexed, 0x60 access bank
   task automatic t_index();
      @(posedge CLK_SYS);
      EXT_SET_EN <= 1'b1;
      INDEX_BASE <= 12'h400;
      load(12'h45f, 8'h81);
      op(1'b0, 8'h5f, 1'b0, 1'b0, 8'h03, 12'h45f);
      load(12'hf60, 8'h02);
      op(1'b0, 8'h60, 1'b0, 1'b0, 8'h04, 12'hf60);
      @(posedge CLK_SYS);
      EXT_SET_EN <= 1'b0;
      load(12'h05f, 8'h10);
      op(1'b0, 8'h5f, 1'b0, 1'b0, 8'h20, 12'h05f);
   endtask

   // Request held high through BUSY is refused: the changed field must not be taken
   task automatic t_refuse();
      @(posedge CLK_SYS);
      OP_VALID <= 1'b1;
      OP_SEL <= 1'b0;
      OP_FILE <= 8'h20;
      OP_DEST <= 1'b0;
      OP_ACCESS <= 1'b1;
      @(posedge CLK_SYS);
      OP_FILE <= 8'h21;
      repeat (2) @(posedge CLK_SYS);
      OP_VALID <= 1'b0;
      #1;
      chk("refused_done", 12'h001, {11'h000, DONE});
      chk("refused_addr", 12'h320, RESULT_ADDR);
      chk("refused_result", 12'h0ae, {4'h0, RESULT});
   endtask

   initial begin
      repeat (10) @(posedge CLK_SYS);
      NRST <= 1'b1;
      t_reset();
      t_left();
      t_right();
      t_index();
      t_refuse();
      summarize();
   end
endmodule // brd_rotate_top_bench
